// *** hw/ext_irq_input_remap.sv ***
// Remap registers, lock sequence and shadow check behind AXI4-Lite
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module ext_irq_input_remap (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output wire logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output wire logic        wready,
  output wire logic [1:0]  bresp,
  output wire logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output wire logic        arready,
  output wire logic [31:0] rdata,
  output wire logic [1:0]  rresp,
  output wire logic        rvalid,
  input  wire logic        rready,
  input  wire logic [25:0] remapPins,
  input  wire logic        singleSessionCfg,
  output wire logic        externalIrq1,
  output wire logic        externalIrq2,
  output wire logic        remapLock,
  output wire logic        cfgMismatchReset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // =====================================================================
  // Write channel capture
  logic        awHeld_r, wHeld_r, bvalid_r;
  logic [7:0]  awAddr_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  logic [1:0]  bresp_r;
  wire logic   awFire = awvalid && awready;
  wire logic   wFire  = wvalid && wready;
  wire logic   wrFire = awHeld_r && wHeld_r && !bvalid_r;
  assign awready = !awHeld_r;
  assign wready  = !wHeld_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;

  // =====================================================================
  // Write decode
  wire logic       wrOsc = awAddr_r == ext_irq_remap_pkg::OFF_OSC_CTRL;
  wire logic       wrSts = awAddr_r == ext_irq_remap_pkg::OFF_STATUS;
  wire logic       wrMap = awAddr_r >= ext_irq_remap_pkg::OFF_MAP_BASE &&
                           awAddr_r <  ext_irq_remap_pkg::OFF_MAP_END &&
                           awAddr_r[1:0] == 2'h0;
  wire logic [7:0] wrOff = awAddr_r - ext_irq_remap_pkg::OFF_MAP_BASE;
  wire logic [4:0] wrIdx = wrOff[6:2];
  wire logic       wrOk  = wrOsc || wrSts || wrMap;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      bvalid_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
      bresp_r  <= 2'h0;
    end else begin
      if (awFire) begin
        awHeld_r <= 1'b1;
        awAddr_r <= awaddr;
      end else if (wrFire) awHeld_r <= 1'b0;
      if (wFire) begin
        wHeld_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end else if (wrFire) wHeld_r <= 1'b0;
      if (wrFire) begin
        bvalid_r <= 1'b1;
        // Locked writes still answer OKAY so software sees no difference
        bresp_r  <= wrOk ? ext_irq_remap_pkg::RESP_OKAY
                         : ext_irq_remap_pkg::RESP_DECERR;
      end else if (bready) bvalid_r <= 1'b0;
    end
  end

  // =====================================================================
  // Lock bit and unlock sequence
  ext_irq_remap_pkg::unlock_t unlState_r, unlState_nxt;
  logic lock_r, setOnce_r;
  wire logic       oscLowWr = wrFire && wrOsc && wStrb_r[0];
  wire logic [7:0] oscByte  = wData_r[7:0];
  wire logic       wantLock = oscByte[ext_irq_remap_pkg::LOCK_BIT];
  wire logic       keepLock = singleSessionCfg && setOnce_r;
  wire logic       lockNew  = wantLock || keepLock;

  always_comb begin
    unlState_nxt = unlState_r;
    if (wrFire) begin
      unlState_nxt = ext_irq_remap_pkg::UNL_IDLE;
      if (oscLowWr) begin
        case (unlState_r)
          ext_irq_remap_pkg::UNL_IDLE: begin
            if (oscByte == ext_irq_remap_pkg::UNLOCK_KEY1)
              unlState_nxt = ext_irq_remap_pkg::UNL_KEY1;
          end
          ext_irq_remap_pkg::UNL_KEY1: begin
            if (oscByte == ext_irq_remap_pkg::UNLOCK_KEY2)
              unlState_nxt = ext_irq_remap_pkg::UNL_OPEN;
          end
          default: unlState_nxt = ext_irq_remap_pkg::UNL_IDLE;
        endcase
      end
    end
  end

  wire logic lockWr = oscLowWr && unlState_r == ext_irq_remap_pkg::UNL_OPEN;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unlState_r <= ext_irq_remap_pkg::UNL_IDLE;
      lock_r     <= ext_irq_remap_pkg::LOCK_RESET;
      setOnce_r  <= 1'b0;
    end else begin
      unlState_r <= unlState_nxt;
      if (lockWr) lock_r <= lockNew;
      if (lockWr && lockNew) setOnce_r <= 1'b1;
    end
  end
  assign remapLock = lock_r;

  // =====================================================================
  // Remap registers with shadow copies
  logic [15:0] mapReg_r [ext_irq_remap_pkg::NUM_MAPS];
  logic [15:0] shadow_r [ext_irq_remap_pkg::NUM_MAPS];
  logic [ext_irq_remap_pkg::NUM_MAPS-1:0] misMatch;
  genvar gi;
  generate
    for (gi = 0; gi < ext_irq_remap_pkg::NUM_MAPS; gi++) begin : g_map
      localparam logic [15:0] MASK = ext_irq_remap_pkg::mapMask(gi);
      localparam logic [15:0] RST  = ext_irq_remap_pkg::mapReset(gi);
      wire logic hit = wrFire && wrMap && wrIdx == 5'(gi) && !lock_r;
      wire logic [15:0] merged = {
        wStrb_r[1] ? wData_r[15:8] : mapReg_r[gi][15:8],
        wStrb_r[0] ? wData_r[7:0]  : mapReg_r[gi][7:0]};
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mapReg_r[gi] <= RST;
          shadow_r[gi] <= RST;
        end else if (hit) begin
          mapReg_r[gi] <= merged & MASK;
          shadow_r[gi] <= merged & MASK;
        end
      end
      assign misMatch[gi] = mapReg_r[gi] != shadow_r[gi];
    end
  endgenerate

  logic mismatch_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) mismatch_r <= 1'b0;
    else mismatch_r <= |misMatch;
  end
  assign cfgMismatchReset = mismatch_r;

  // =====================================================================
  // Read channel
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  wire logic       rdOsc = araddr == ext_irq_remap_pkg::OFF_OSC_CTRL;
  wire logic       rdSts = araddr == ext_irq_remap_pkg::OFF_STATUS;
  wire logic       rdMap = araddr >= ext_irq_remap_pkg::OFF_MAP_BASE &&
                           araddr <  ext_irq_remap_pkg::OFF_MAP_END &&
                           araddr[1:0] == 2'h0;
  wire logic [7:0] rdOff = araddr - ext_irq_remap_pkg::OFF_MAP_BASE;
  wire logic [4:0] rdIdx = rdOff[6:2];
  wire logic [31:0] oscWord = {25'h0, lock_r, 6'h00};
  // Bit 2 is spare, so the word is padded there to keep the unlock state at bits 4:3
  wire logic [31:0] stsWord = {27'h0, unlState_r, 1'b0, setOnce_r,
                               mismatch_r};
  wire logic [31:0] mapWord = rdMap ? {16'h0000, mapReg_r[rdIdx]}
                                    : 32'h0000_0000;
  wire logic [31:0] rdWord  = rdOsc ? oscWord : rdSts ? stsWord : mapWord;
  wire logic        rdOk    = rdOsc || rdSts || rdMap;
  assign arready = !rvalid_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= 2'h0;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rdWord;
      rresp_r  <= rdOk ? ext_irq_remap_pkg::RESP_OKAY
                       : ext_irq_remap_pkg::RESP_DECERR;
    end else if (rready) rvalid_r <= 1'b0;
  end

  // =====================================================================
  // Pin routing
  remap_if rif (.clk(clk), .rst_n(rst_n));
  assign rif.pins   = remapPins;
  assign rif.sel[0] = mapReg_r[0][12:8];
  assign rif.sel[1] = mapReg_r[1][4:0];
  pin_select_mux u_mux (.rif(rif.mux));
  assign externalIrq1 = rif.irq[0];
  assign externalIrq2 = rif.irq[1];

  // =====================================================================
  // Checks
  locked_write_a: assert property (
    wrFire && wrMap && wrIdx == 5'h00 && lock_r |=> $stable(mapReg_r[0]))
    else $error("locked write changed map 0");
  open_write_a: assert property (
    wrFire && wrMap && wrIdx == 5'h01 && !lock_r && wStrb_r[0]
    |=> mapReg_r[1][4:0] == $past(wData_r[4:0]))
    else $error("unlocked write lost");
  map0_field_a: assert property (
    (mapReg_r[0] & ~ext_irq_remap_pkg::IRQ1_MASK) == 16'h0000 and
    ($rose(rst_n) |-> mapReg_r[0] == ext_irq_remap_pkg::IRQ1_MASK))
    else $error("map 0 layout wrong");
  map1_field_a: assert property (
    (mapReg_r[1] & ~ext_irq_remap_pkg::IRQ2_MASK) == 16'h0000)
    else $error("map 1 reserved bits set");
  last_map_a: assert property (
    arvalid && arready && araddr == 8'h80 |=> rresp == 2'h0)
    else $error("seventeenth register missing");
  lock_key_a: assert property (
    $changed(lock_r) |-> $past(unlState_r) == ext_irq_remap_pkg::UNL_OPEN)
    else $error("lock changed without key");
  shadow_reset_a: assert property (
    |misMatch |=> cfgMismatchReset)
    else $error("mismatch not reported");
  one_session_a: assert property (
    singleSessionCfg && setOnce_r && lock_r |=> lock_r)
    else $error("lock cleared in single session");
  resp_hold_a: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
endmodule : ext_irq_input_remap

// *** hw/pin_select_mux.sv ***
// Routes one remappable pin to each external interrupt input
`timescale 1ns/1ps
module pin_select_mux (
  remap_if.mux rif
);
  default clocking cb @(posedge rif.clk); endclocking
  default disable iff (!rif.rst_n);

  genvar ch;
  generate
    for (ch = 0; ch < ext_irq_remap_pkg::NUM_IRQ; ch++) begin : g_ch
      // =================================================================
      // Pin selection
      // select decode
      wire logic inRange = rif.sel[ch] <= ext_irq_remap_pkg::LAST_PIN;
      wire logic picked  = inRange ? rif.pins[rif.sel[ch]] : 1'b0;
      logic      irq_r;
      always_ff @(posedge rif.clk or negedge rif.rst_n) begin
        if (!rif.rst_n) irq_r <= 1'b0;
        else irq_r <= picked;
      end
      assign rif.irq[ch] = irq_r;

      route_pin1_a: assert property (
        rif.sel[ch] == 5'h01 |=> rif.irq[ch] == $past(rif.pins[1]))
        else $error("pin 1 not routed");
      route_pin25_a: assert property (
        rif.sel[ch] == 5'h19 |=> rif.irq[ch] == $past(rif.pins[25]))
        else $error("pin 25 not routed");
      unused_low_a: assert property (
        rif.sel[ch] > 5'h19 |=> !rif.irq[ch])
        else $error("unassigned select not low");
      pin_zero_a: assert property (
        rif.sel[ch] == 5'h00 |=> rif.irq[ch] == $past(rif.pins[0]))
        else $error("select zero not pin 0");
    end
  endgenerate
endmodule : pin_select_mux

// *** pkg/ext_irq_remap_pkg.sv ***
// Constants for the external interrupt input remapping block
// =====================================================================
// How it works
// - Remap register writes are dropped while the remap lock bit is set.
// - Seventeen remap registers exist: nine input maps, eight output maps.
// - Input map 0 holds irq1 pin select in bits 12:8, reset ones.
// - Input map 1 holds irq2 pin select in bits 4:0, reset ones.
// - Select value n routes remappable pin n; all ones ties input low.
// - Shadow copies are compared continuously; mismatch raises a reset.
// - With single session config set, the lock cannot be cleared again.
package ext_irq_remap_pkg;
  // =====================================================================
  // Register map
  localparam int NUM_IN_MAPS  = 9;
  localparam int NUM_OUT_MAPS = 8;
  localparam int NUM_MAPS     = NUM_IN_MAPS + NUM_OUT_MAPS;
  localparam int NUM_PINS     = 26;
  localparam int NUM_IRQ      = 2;
  localparam logic [7:0] OFF_OSC_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_MAP_BASE = 8'h40;
  localparam logic [7:0] OFF_MAP_END  = 8'h84;
  // =====================================================================
  // Fields and reset values
  localparam int LOCK_BIT = 6;
  localparam logic [15:0] IRQ1_MASK  = 16'h1f00;
  localparam logic [15:0] IRQ2_MASK  = 16'h001f;
  localparam logic [15:0] PAIR_MASK  = 16'h1f1f;
  localparam logic [15:0] OUT_RESET  = 16'h0000;
  localparam logic        LOCK_RESET = 1'b0;
  localparam logic [7:0]  UNLOCK_KEY1 = 8'h46;
  localparam logic [7:0]  UNLOCK_KEY2 = 8'h57;
  localparam logic [4:0]  LAST_PIN    = 5'h19;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {UNL_IDLE, UNL_KEY1, UNL_OPEN} unlock_t;

  function automatic logic [15:0] mapMask(input int idx);
    if (idx == 0) return IRQ1_MASK;
    if (idx == 1) return IRQ2_MASK;
    return PAIR_MASK;
  endfunction : mapMask

  function automatic logic [15:0] mapReset(input int idx);
    return (idx < NUM_IN_MAPS) ? mapMask(idx) : OUT_RESET;
  endfunction : mapReset
endpackage : ext_irq_remap_pkg

// *** pkg/remap_if.sv ***
// Select fields, pins and routed interrupts between top and mux
`timescale 1ns/1ps
interface remap_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic [4:0]  sel [ext_irq_remap_pkg::NUM_IRQ];
  logic [ext_irq_remap_pkg::NUM_PINS-1:0] pins;
  logic [ext_irq_remap_pkg::NUM_IRQ-1:0]  irq;
  modport ctrl (input clk, input rst_n, output sel, output pins, input irq);
  modport mux  (input clk, input rst_n, input sel, input pins, output irq);
endinterface : remap_if

// *** verification/ext_irq_input_remap_tb.sv ***
// Self-checking bench for the external interrupt input remap block
`timescale 1ns/1ps
module ext_irq_input_remap_tb;
  // =====================================================================
  // Signals
  logic        clk;
  logic        rst_n;
  logic [7:0]  awaddr;
  logic [7:0]  araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready, singleSessionCfg;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [31:0] rdata;
  logic [25:0] remapPins;
  logic        externalIrq1, externalIrq2, remapLock, cfgMismatchReset;
  int          errCount;
  int          nCompared;
  logic [31:0] v;
  logic [1:0]  r;

  ext_irq_input_remap i_dut (
    .clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .remapPins(remapPins), .singleSessionCfg(singleSessionCfg),
    .externalIrq1(externalIrq1), .externalIrq2(externalIrq2),
    .remapLock(remapLock), .cfgMismatchReset(cfgMismatchReset));

  // =====================================================================
  // Bus and check tasks
  task automatic check(input logic [31:0] seen, exp, input string msg);
    nCompared++;
    if (seen !== exp) begin
      errCount++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // Bounded waits so a dead handshake ends in a mismatch, not a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a; wdata <= d; wstrb <= 4'h3;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      n++;
    end while (!(bvalid === 1'b1 && !awvalid && !wvalid) && n < 50);
    r = bresp;
    bready <= 1'b0;
    check(32'(n < 50), 32'h1, "write answer");
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      n++;
    end while (!(rvalid === 1'b1 && !arvalid) && n < 50);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    check(32'(n < 50), 32'h1, "read answer");
  endtask : rd

  task automatic lockSeq(input logic val);
    wr(8'h00, 32'h46);
    wr(8'h00, 32'h57);
    wr(8'h00, val ? 32'h40 : 32'h00);
  endtask : lockSeq

  // =====================================================================
  // Scenarios
  task automatic t_reset();
    rd(8'h40);
    check(v, 32'h0000_1f00, "map0 reset");
    rd(8'h44);
    check(v, 32'h0000_001f, "map1 reset");
    rd(8'h80);
    check(32'(r), 32'h0, "map16 okay");
    rd(8'h84);
    check(32'(r), 32'h3, "past end decerr");
    wr(8'h84, 32'h0000_0000);
    check(32'(r), 32'h3, "write past end decerr");
    check(32'(remapLock), 32'h0, "lock reset");
    $display("test reset done");
  endtask : t_reset

  task automatic t_route();
    logic [4:0]  codes [6] = '{5'h00, 5'h01, 5'h0c, 5'h19, 5'h1a, 5'h1f};
    logic [31:0] e;
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40);
    check(v, 32'h0000_1f00, "map0 bits");
    wr(8'h44, 32'hffff_ffff);
    rd(8'h44);
    check(v, 32'h0000_001f, "map1 bits");
    foreach (codes[i]) begin
      wr(8'h40, {19'h0, codes[i], 8'h00});
      wr(8'h44, {27'h0, codes[i]});
      for (int lvl = 0; lvl < 2; lvl++) begin
        @(posedge clk);
        remapPins <= (codes[i] < 5'h1a) ?
          (lvl ? ~(26'h1 << codes[i]) : (26'h1 << codes[i])) : 26'h3ffffff;
        repeat (3) @(posedge clk);
        #1;
        e = 32'(!lvl && codes[i] < 5'h1a);
        check(32'(externalIrq1), e, "irq1");
        check(32'(externalIrq2), e, "irq2");
      end
    end
    $display("test route done");
  endtask : t_route

  task automatic t_lock();
    lockSeq(1'b1);
    check(32'(remapLock), 32'h1, "lock set");
    rd(8'h00);
    check(v, 32'h0000_0040, "lock bit read");
    wr(8'h40, 32'h0000_0500);
    check(32'(r), 32'h0, "locked write okay");
    rd(8'h40);
    check(v, 32'h0000_1f00, "locked map0");
    wr(8'h00, 32'h46);
    rd(8'h04);
    check(v, 32'h0000_000a, "first key state");
    wr(8'h44, 32'h0000_0000);
    wr(8'h00, 32'h57);
    wr(8'h00, 32'h0000_0000);
    check(32'(remapLock), 32'h1, "broken seq");
    lockSeq(1'b0);
    check(32'(remapLock), 32'h0, "lock cleared");
    wr(8'h40, 32'h0000_0500);
    rd(8'h40);
    check(v, 32'h0000_0500, "unlocked map0");
    @(posedge clk);
    singleSessionCfg <= 1'b1;
    lockSeq(1'b1);
    lockSeq(1'b0);
    check(32'(remapLock), 32'h1, "one session");
    check(32'(cfgMismatchReset), 32'h0, "no mismatch");
    $display("test lock done");
  endtask : t_lock

  // =====================================================================
  // Verdict and run control
  task automatic summarize();
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    #(40 * 20000);
    errCount++;
    summarize();
  end

  initial begin
    errCount = 0; nCompared = 0; rst_n = 1'b0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; remapPins = 26'h0; singleSessionCfg = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_route();
    t_lock();
    summarize();
  end
endmodule : ext_irq_input_remap_tb
